/* File: src/rssc_top.v */
// Purpose: serial-port register file, state control and status of the receiver
// Assumes: serial clock high and low phases each at least 6 clk periods
// Notes:   pins pass three synchroniser flip-flops and a filter flip-flop before use
`timescale 1ns/1ps
`include "rssc_consts.vh"
module rssc_top (
  input wire clk,
  input wire rst,
  input wire power_down_pin,
  input wire spi_csb_n,
  input wire spi_sck,
  input wire spi_sdi,
  output wire spi_sdo,
  output wire spi_sdo_oe_n,
  input wire pll_lock_in,
  input wire demod_bit,
  input wire bit_tick,
  input wire ask_threshold_method,
  output reg data_pin,
  output wire crystal_osc_enable,
  output wire wakeup_timer_enable,
  output wire receiver_enable,
  output reg sleep_active,
  output wire precharged_lowpass_method,
  output reg [7:0] ask_floor_signed,
  output wire ask_settling,
  output wire [1:0] receiver_state
);

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  localparam [4:0] PIN_IDLE = `RSSC_PIN_IDLE; // idle levels, no false edge at release
  wire [4:0] pin_in;
  reg [4:0] s1_r, s2_r, s3_r, filt_r;
  assign pin_in = {pll_lock_in, spi_sdi, spi_sck, spi_csb_n, power_down_pin};
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : g_sync
      always @(posedge clk) begin
        if (rst) begin
          s1_r[gi] <= PIN_IDLE[gi];
          s2_r[gi] <= PIN_IDLE[gi];
          s3_r[gi] <= PIN_IDLE[gi];
          filt_r[gi] <= PIN_IDLE[gi];
        end else begin
          s1_r[gi] <= pin_in[gi];
          s2_r[gi] <= s1_r[gi];
          s3_r[gi] <= s2_r[gi];
          // a change counts only once two stages agree
          if (s2_r[gi] == s3_r[gi]) begin
            filt_r[gi] <= s3_r[gi];
          end
        end
      end
    end
  endgenerate
  wire pd_f = filt_r[0];
  wire csb_f = filt_r[1];
  wire sck_f = filt_r[2];
  wire sdi_f = filt_r[3];
  wire lock_f = filt_r[4];
  // power-down pin high holds all control state at reset values
  wire hold = rst | pd_f;

  // ****************************************************************
  // decode
  // ****************************************************************
  function [4:0] cfg_slot;
    input [6:0] a;
    begin
      if (a <= `RSSC_BANK_LAST) begin
        cfg_slot = {1'b1, a[3:0]};
      end else if (a == `RSSC_ADDR_FRONT_END) begin
        cfg_slot = {1'b1, `RSSC_SLOT_FRONT_END};
      end else begin
        cfg_slot = 5'h00;
      end
    end
  endfunction

  // ****************************************************************
  // serial port slave
  // ****************************************************************
  reg sck_d_r;
  reg [2:0] bit_cnt_r;
  reg [7:0] rx_r;
  reg [7:0] tx_r;
  reg first_r;
  reg rw_r;
  reg [6:0] addr_r;
  reg [1:0] ld_r;
  wire frame = ~csb_f;
  wire sck_rise = frame & sck_f & ~sck_d_r;
  wire sck_fall = frame & ~sck_f & sck_d_r;
  wire [7:0] rx_byte = {rx_r[6:0], sdi_f};
  wire byte_done = sck_rise & (bit_cnt_r == 3'h7);
  wire wr_byte = byte_done & ~first_r & ~rw_r;
  wire [4:0] wr_slot = cfg_slot(addr_r);
  wire [4:0] rd_slot = cfg_slot(addr_r);
  wire [7:0] mem_rd;
  reg [7:0] rd_mux;

  rssc_cfg_mem u_mem (
    .clk(clk),
    .wr_en(wr_byte & wr_slot[4]),
    .wr_idx(wr_slot[3:0]),
    .wr_data(rx_byte),
    .rd_idx(rd_slot[3:0]),
    .rd_data(mem_rd)
  );

  always @(posedge clk) begin
    if (hold) begin
      sck_d_r <= 1'b0;
      bit_cnt_r <= 3'h0;
      rx_r <= 8'h00;
      tx_r <= 8'h00;
      first_r <= 1'b1;
      rw_r <= 1'b0;
      addr_r <= 7'h00;
      ld_r <= 2'h0;
    end else begin
      sck_d_r <= sck_f;
      ld_r <= {ld_r[0], 1'b0};
      if (!frame) begin
        bit_cnt_r <= 3'h0;
        first_r <= 1'b1;
      end else begin
        if (sck_rise) begin
          rx_r <= rx_byte;
          bit_cnt_r <= bit_cnt_r + 3'h1;
        end
        // first data bit stays on the line across the byte boundary
        if (sck_fall && bit_cnt_r != 3'h0) begin
          tx_r <= {tx_r[6:0], 1'b0};
        end
        if (byte_done) begin
          first_r <= 1'b0;
          if (first_r) begin
            rw_r <= rx_byte[7];
            addr_r <= rx_byte[6:0];
            ld_r <= {ld_r[0], rx_byte[7]};
          end else if (rw_r) begin
            ld_r <= {ld_r[0], 1'b1};
          end else begin
            addr_r <= addr_r + 7'h01;
          end
        end
        // two cycles let the registered bank read catch up with addr_r
        if (ld_r[1]) begin
          tx_r <= rd_mux;
          addr_r <= addr_r + 7'h01;
        end
      end
    end
  end

  assign spi_sdo = tx_r[7];
  assign spi_sdo_oe_n = ~(frame & rw_r & ~first_r);

  // ****************************************************************
  // control and status registers
  // ****************************************************************
  reg [2:0] state_ctrl_r;
  reg [1:0] status_r;
  reg [1:0] rx_state_r;
  reg [15:0] poll_cnt_r;
  reg [3:0] settle_r;

  always @(posedge clk) begin
    if (hold) begin
      state_ctrl_r <= `RSSC_STATE_CTRL_RST;
      ask_floor_signed <= 8'h00;
    end else if (wr_byte) begin
      if (addr_r == `RSSC_ADDR_STATE_CTRL) begin
        state_ctrl_r <= rx_byte[2:0];
      end
      if (addr_r == `RSSC_ADDR_FLOOR) begin
        ask_floor_signed <= rx_byte;
      end
      // revision, readback and status addresses take no write
    end
  end

  assign crystal_osc_enable = state_ctrl_r[`RSSC_BIT_XO_EN];
  assign wakeup_timer_enable = state_ctrl_r[`RSSC_BIT_WAKEUP_TIMER_ENABLE];
  assign receiver_enable = crystal_osc_enable & state_ctrl_r[`RSSC_BIT_HRX_EN];
  assign precharged_lowpass_method = ~ask_threshold_method;
  assign receiver_state = rx_state_r;

  always @(posedge clk) begin
    if (hold) begin
      status_r <= `RSSC_STATUS_RST;
      sleep_active <= 1'b1;
      data_pin <= 1'b0;
    end else begin
      // lock is meaningless with the oscillator stopped
      status_r <= {1'b0, lock_f & crystal_osc_enable};
      sleep_active <= ~crystal_osc_enable;
      data_pin <= (rx_state_r == `RSSC_ST_HOST_RX) ? demod_bit : 1'b0;
    end
  end

  // ****************************************************************
  // receiver state machine
  // ****************************************************************
  always @(posedge clk) begin
    if (hold) begin
      rx_state_r <= `RSSC_ST_STANDBY;
      poll_cnt_r <= 16'h0000;
    end else begin
      case (rx_state_r)
        `RSSC_ST_STANDBY: begin
          poll_cnt_r <= 16'h0000;
          if (receiver_enable) begin
            rx_state_r <= `RSSC_ST_HOST_RX;
          end else if (crystal_osc_enable && wakeup_timer_enable) begin
            rx_state_r <= `RSSC_ST_POLL_WAIT;
          end
        end
        `RSSC_ST_HOST_RX: begin
          if (!receiver_enable) begin
            rx_state_r <= `RSSC_ST_STANDBY;
          end
        end
        `RSSC_ST_POLL_WAIT, `RSSC_ST_POLL_RX: begin
          poll_cnt_r <= poll_cnt_r + 16'h0001;
          if (receiver_enable) begin
            rx_state_r <= `RSSC_ST_HOST_RX;
          end else if (!(crystal_osc_enable && wakeup_timer_enable)) begin
            rx_state_r <= `RSSC_ST_STANDBY;
          end else if (rx_state_r == `RSSC_ST_POLL_WAIT &&
                       poll_cnt_r >= `RSSC_POLL_WAIT_CYC - 16'h0001) begin
            rx_state_r <= `RSSC_ST_POLL_RX;
            poll_cnt_r <= 16'h0000;
          end else if (rx_state_r == `RSSC_ST_POLL_RX &&
                       poll_cnt_r >= `RSSC_POLL_DET_CYC - 16'h0001) begin
            rx_state_r <= `RSSC_ST_POLL_WAIT;
            poll_cnt_r <= 16'h0000;
          end
        end
        default: begin
          rx_state_r <= `RSSC_ST_STANDBY;
        end
      endcase
    end
  end

  // ****************************************************************
  // ask threshold settling window
  // ****************************************************************
  always @(posedge clk) begin
    if (hold) begin
      settle_r <= 4'h0;
    end else if (rx_state_r != `RSSC_ST_HOST_RX) begin
      // re-armed so every receive entry with the precharged lowpass method starts a fresh window
      settle_r <= precharged_lowpass_method ? `RSSC_ASK_SETTLE_BITS : 4'h0;
    end else if (bit_tick && settle_r != 4'h0) begin
      settle_r <= settle_r - 4'h1;
    end
  end

  assign ask_settling = (rx_state_r == `RSSC_ST_HOST_RX) & (settle_r != 4'h0);

  // ****************************************************************
  // read data
  // ****************************************************************
  always @* begin
    rd_mux = 8'h00;
    if (rd_slot[4]) begin
      rd_mux = mem_rd;
    end else if (addr_r == `RSSC_ADDR_STATE_CTRL) begin
      rd_mux = {5'h00, state_ctrl_r};
    end else if (addr_r == `RSSC_ADDR_STATE_RDBK) begin
      rd_mux = {6'h00, rx_state_r};
    end else if (addr_r == `RSSC_ADDR_REV) begin
      rd_mux = {5'h00, `RSSC_CHIP_REV};
    end else if (addr_r == `RSSC_ADDR_STATUS) begin
      rd_mux = {6'h00, status_r};
    end
  end

endmodule // rssc_top

/* File: src/rssc_consts.vh */
// Purpose: register map, field positions, reset values and counts of the
//          receiver state/status control block
// Assumes: 8-bit registers, 7-bit register addresses on the serial port
// Notes:   definitions only
`ifndef RSSC_CONSTS_VH
`define RSSC_CONSTS_VH

// ****************************************************************
// register addresses
// ****************************************************************
`define RSSC_ADDR_W 7
`define RSSC_BANK_LAST 7'h0e
`define RSSC_ADDR_FLOOR 7'h04
`define RSSC_ADDR_STATE_CTRL 7'h14
`define RSSC_ADDR_STATE_RDBK 7'h15
`define RSSC_ADDR_FRONT_END 7'h19
`define RSSC_ADDR_REV 7'h1f
`define RSSC_ADDR_STATUS 7'h27
`define RSSC_SLOT_FRONT_END 4'hf

// ****************************************************************
// fields and reset values
// ****************************************************************
`define RSSC_BIT_XO_EN 2
`define RSSC_BIT_WAKEUP_TIMER_ENABLE 1
`define RSSC_BIT_HRX_EN 0
`define RSSC_STATE_CTRL_RST 3'h0
`define RSSC_STATUS_RST 2'h0
`define RSSC_PIN_IDLE 5'h03
`define RSSC_CHIP_REV 3'h1
`define RSSC_CMD_STANDBY 8'h04
`define RSSC_CMD_RECEIVE 8'h05
`define RSSC_CMD_SLEEP 8'h00

// receiver state codes, as shown in the readback field
`define RSSC_ST_STANDBY 2'h0
`define RSSC_ST_HOST_RX 2'h1
`define RSSC_ST_POLL_WAIT 2'h2
`define RSSC_ST_POLL_RX 2'h3

// ****************************************************************
// counts
// ****************************************************************
`define RSSC_ASK_SETTLE_BITS 4'hc
`define RSSC_POLL_WAIT_CYC 16'h0064
`define RSSC_POLL_DET_CYC 16'h000a

`endif

/* File: src/rssc_cfg_mem.v */
// Purpose: 16-entry configuration bank store
// Assumes: one write and one read port, same clock
// Notes:   read data registered, one cycle latency; contents not reset
`timescale 1ns/1ps
module rssc_cfg_mem (
  input wire clk,
  input wire wr_en,
  input wire [3:0] wr_idx,
  input wire [7:0] wr_data,
  input wire [3:0] rd_idx,
  output reg [7:0] rd_data
);

  reg [7:0] mem_r [0:15];

  always @(posedge clk) begin
    if (wr_en) begin
      mem_r[wr_idx] <= wr_data;
    end
    rd_data <= mem_r[rd_idx];
  end

endmodule // rssc_cfg_mem

/* File: sim/rssc_chk_sva.sv */
// Purpose: port checks of the receiver state/status control block
// Assumes: one clk domain, synchronous rst
// Notes:   bound to rssc_top below
`timescale 1ns/1ps
module rssc_chk (
  input wire clk,
  input wire rst,
  input wire spi_csb_n,
  input wire bit_tick,
  input wire demod_bit,
  input wire ask_threshold_method,
  input wire data_pin,
  input wire crystal_osc_enable,
  input wire wakeup_timer_enable,
  input wire receiver_enable,
  input wire sleep_active,
  input wire precharged_lowpass_method,
  input wire [7:0] ask_floor_signed,
  input wire ask_settling,
  input wire [1:0] receiver_state
);
  // ****
  // helper and properties
  // ****
  // ticks seen while settling; must stop at twelve
  reg [4:0] tick_r;
  always @(posedge clk) begin
    if (rst || !ask_settling) tick_r <= 5'h0;
    else tick_r <= tick_r + {4'h0, bit_tick};
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence host2;
    (receiver_state == 2'h1) [*2];
  endsequence
  sequence quiet2;
    (receiver_state != 2'h1) [*2];
  endsequence
  rx_needs_xo_a: assert property (receiver_enable |-> crystal_osc_enable)
    else $error("receiver on without oscillator");
  xo_wake_a: assert property ($rose(crystal_osc_enable) |-> ##[0:2] !sleep_active)
    else $error("still asleep with oscillator on");
  xo_sleep_a: assert property ($fell(crystal_osc_enable) |-> ##[0:2] sleep_active)
    else $error("not asleep after oscillator off");
  host_entry_a: assert property ($rose(receiver_enable) |-> ##[0:2] receiver_state == 2'h1)
    else $error("host receive not entered");
  data_follow_a: assert property (host2 |-> data_pin == $past(demod_bit))
    else $error("data pin not following demodulator");
  data_quiet_a: assert property (quiet2 |-> !data_pin)
    else $error("data pin active outside receive");
  settle_start_a: assert property ($rose(receiver_state == 2'h1) &&
    !ask_threshold_method |-> ##[0:1] ask_settling)
    else $error("settling not started");
  settle_len_a: assert property ($fell(ask_settling) && receiver_state == 2'h1
    |-> tick_r == 5'd12)
    else $error("settling not twelve bits");
  method_inv_a: assert property (precharged_lowpass_method == !ask_threshold_method)
    else $error("method flag wrong");
  poll_order_a: assert property ($rose(receiver_state == 2'h3)
    |-> $past(receiver_state) == 2'h2)
    else $error("polling receive not after wait");
  cfg_hold_a: assert property (spi_csb_n [*8] |->
    $stable({ask_floor_signed, crystal_osc_enable, wakeup_timer_enable}))
    else $error("settings moved without access");
endmodule // rssc_chk
bind rssc_top rssc_chk u_chk (.clk, .rst, .spi_csb_n, .bit_tick, .demod_bit,
  .ask_threshold_method, .data_pin, .crystal_osc_enable, .wakeup_timer_enable,
  .receiver_enable, .sleep_active, .precharged_lowpass_method, .ask_floor_signed,
  .ask_settling, .receiver_state);

/* File: sim/rssc_mcu.sv */
// Purpose: serial-port controller model on the far side
// Assumes: six clk per serial clock phase, the least the port needs
// Notes:   clock idles low; data line inverted once released
`timescale 1ns/1ps
module rssc_mcu (
  input wire clk,
  input wire sdo,
  output reg csb_n = 1'b1,
  output reg sck = 1'b0,
  output reg sdi = 1'b0,
  output reg [7:0] rd_byte = 8'h00,
  output reg rd_vld = 1'b0
);
  // ****
  // byte and frame transfer
  // ****
  reg [7:0] dat [0:15];
  task sbyte(input [7:0] b, output [7:0] r);
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        sdi <= b[i];
        repeat (6) @(posedge clk);
        sck <= 1'b1;
        r[i] = sdo;
        repeat (6) @(posedge clk);
        sck <= 1'b0;
      end
    end
  endtask
  task frame(input rw, input [6:0] a, input integer n);
    integer k;
    reg [7:0] r;
    begin
      csb_n <= 1'b0;
      sbyte({rw, a}, r);
      for (k = 0; k < n; k = k + 1) begin
        sbyte(dat[k], r);
        if (rw) begin
          rd_byte <= r;
          rd_vld <= 1'b1;
          @(posedge clk);
          rd_vld <= 1'b0;
        end
      end
      repeat (6) @(posedge clk);
      csb_n <= 1'b1;
      sdi <= ~sdi;
      repeat (6) @(posedge clk);
    end
  endtask
endmodule // rssc_mcu

/* File: sim/receiver_state_status_control_tb.sv */
// Purpose: self-checking bench of the receiver state/status control
// Assumes: 10 MHz clk, serial controller model rssc_mcu
// Notes:   read bytes checked in order against a queue of expectations
`timescale 1ns/1ps
`include "rssc_consts.vh"
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin mismatches++; \
  $display("Error %0t: got %h exp %h", $time, a, e); end end
module receiver_state_status_control_tb;
  reg clk = 1'b0, rst = 1'b1, power_down_pin = 1'b0, pll_lock_in = 1'b0;
  reg demod_bit = 1'b0, bit_tick = 1'b0, ask_threshold_method = 1'b0;
  wire spi_csb_n, spi_sck, spi_sdi, spi_sdo, spi_sdo_oe_n, data_pin, rd_vld;
  wire crystal_osc_enable, wakeup_timer_enable, receiver_enable, sleep_active;
  wire precharged_lowpass_method, ask_settling;
  wire [7:0] ask_floor_signed, rd_byte;
  wire [1:0] receiver_state;
  // released line shows the inverse, so a late output enable corrupts reads
  wire sdo_line = spi_sdo_oe_n ? ~spi_sdo : spi_sdo;
  reg [7:0] exp_q [$];
  reg [7:0] bank [0:14];
  reg [7:0] e;
  integer i, cmp_count = 0, mismatches = 0;
  always #50 clk = ~clk;
  rssc_top uut (.clk, .rst, .power_down_pin, .spi_csb_n, .spi_sck, .spi_sdi, .spi_sdo,
    .spi_sdo_oe_n, .pll_lock_in, .demod_bit, .bit_tick, .ask_threshold_method, .data_pin,
    .crystal_osc_enable, .wakeup_timer_enable, .receiver_enable, .sleep_active,
    .precharged_lowpass_method, .ask_floor_signed, .ask_settling, .receiver_state);
  rssc_mcu mcu (.clk, .sdo(sdo_line), .csb_n(spi_csb_n), .sck(spi_sck), .sdi(spi_sdi),
    .rd_byte, .rd_vld);
  // ****
  // checker of read results
  // ****
  always @(posedge clk) begin
    if (rd_vld) begin
      e = exp_q.pop_front();
      `CHK(rd_byte, e)
    end
  end
  task wr(input [6:0] a, input [7:0] d);
    begin
      mcu.dat[0] = d;
      mcu.frame(1'b0, a, 1);
    end
  endtask
  task rd(input [6:0] a, input [7:0] d);
    begin
      exp_q.push_back(d);
      mcu.frame(1'b1, a, 1);
    end
  endtask
  task wst(input [1:0] s);
    integer n;
    begin
      for (n = 0; n < 400 && receiver_state !== s; n = n + 1) @(posedge clk);
      if (n == 400) begin
        mismatches++;
        results();
      end
    end
  endtask
  task results;
    begin
      $display("compares %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  // ****
  // main sequence
  // ****
  initial begin
    void'($urandom(32'he508));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    power_down_pin <= 1'b1;
    repeat (10000) @(posedge clk);
    power_down_pin <= 1'b0;
    repeat (4000) @(posedge clk);
    rd(7'h1f, {5'h0, `RSSC_CHIP_REV});
    rd(7'h27, 8'h00);
    `CHK(spi_sdo_oe_n, 1'b1)
    rd(7'h14, 8'h00);
    wr(7'h14, 8'h04);
    `CHK({crystal_osc_enable, sleep_active}, 2'b10)
    pll_lock_in <= 1'b1;
    wr(7'h27, 8'hfe);
    wr(7'h1f, 8'hfe);
    rd(7'h27, 8'h01);
    rd(7'h1f, {5'h0, `RSSC_CHIP_REV});
    $display("standby done");
    for (i = 0; i < 15; i++) bank[i] = 8'($urandom);
    bank[4] = 8'h81;
    for (i = 0; i < 15; i++) mcu.dat[i] = bank[i];
    mcu.frame(1'b0, 7'h00, 15);
    wr(7'h19, 8'h95);
    `CHK($signed(ask_floor_signed), -8'sd127)
    for (i = 0; i < 15; i++) exp_q.push_back(bank[i]);
    mcu.frame(1'b1, 7'h00, 15);
    rd(7'h19, 8'h95);
    wr(7'h04, 8'haa);
    `CHK($signed(ask_floor_signed), -8'sd86)
    $display("bank done");
    `CHK(precharged_lowpass_method, 1'b1)
    wr(7'h14, 8'h05);
    `CHK({receiver_enable, receiver_state, ask_settling}, 4'b1011)
    for (i = 0; i < 12; i++) begin
      `CHK(ask_settling, 1'b1)
      bit_tick <= 1'b1;
      demod_bit <= i[0];
      @(posedge clk);
      bit_tick <= 1'b0;
      repeat (2) @(posedge clk);
    end
    `CHK({ask_settling, data_pin}, 2'b01)
    rd(7'h14, 8'h05);
    rd(7'h15, 8'h01);
    wr(7'h14, 8'h00);
    `CHK({crystal_osc_enable, receiver_enable, sleep_active, data_pin}, 4'b0010)
    rd(7'h15, 8'h00);
    $display("receive and sleep done");
    ask_threshold_method <= 1'b1;
    wr(7'h14, 8'h06);
    `CHK(wakeup_timer_enable, 1'b1)
    `CHK(precharged_lowpass_method, 1'b0)
    wst(2'h2);
    wst(2'h3);
    wr(7'h14, 8'h05);
    `CHK({receiver_state, ask_settling}, 3'b010)
    $display("polling done");
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(posedge clk);
    `CHK({crystal_osc_enable, wakeup_timer_enable, receiver_state, sleep_active}, 5'b00001)
    rd(7'h14, 8'h00);
    rd(7'h27, 8'h00);
    $display("reset done");
    results();
  end
endmodule // receiver_state_status_control_tb
